// >>> core/brc_pin_track.sv
// Picks one of three pin inputs by a select code and reports its edges.
// Assumes pin inputs are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module brc_pin_track
  import brc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] sel,
  input wire logic [2:0] pins,
  output logic rise,
  output logic fall
);
  logic level;
  logic prev_q;
  logic prev_d;
  logic sel_prev_q;
  logic [1:0] sel_q;

  // Decode the select code; code zero leaves the function to the sequencer.
  always_comb begin
    case (sel)
      SEL_PIN_FIRST: level = pins[0];
      SEL_PIN_SECOND: level = pins[1];
      SEL_PIN_THIRTEENTH: level = pins[2];
      default: level = 1'b0;
    endcase
    prev_d = level;
  end

  // Edges are suppressed for one cycle after the select changes, so that
  // rerouting to a pin that is already high does not look like a transition.
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_q <= 1'b0;
      sel_q <= SEL_SEQ;
    end else begin
      prev_q <= prev_d;
      sel_q <= sel;
    end
  end

  assign sel_prev_q = (sel_q == sel) && (sel != SEL_SEQ);
  assign rise = sel_prev_q && level && !prev_q;
  assign fall = sel_prev_q && !level && prev_q;
endmodule : brc_pin_track
`default_nettype wire

// >>> core/brc_pkg.sv
// Constants for the step-down rail control register bank.
// Assumes an 8-bit register space reached over a plain strobe port.
package brc_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] MEM_CTRL_ADDR = 8'h23;
  localparam logic [7:0] IO_CTRL_ADDR = 8'h24;
  localparam logic [7:0] PERIPH_CTRL_ADDR = 8'h25;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int RAIL_ON_BIT = 0;
  localparam int ON_SEL_LO = 1;
  localparam int ON_SEL_HI = 2;
  localparam int SEQ_TARGET_BIT = 3;
  localparam int SWITCH_BIT = 4;
  localparam int VOLT_SEL_LO = 5;
  localparam int VOLT_SEL_HI = 6;
  localparam int SWITCH_TARGET_BIT = 7;
  // Pin select codes.
  localparam logic [1:0] SEL_SEQ = 2'h0;
  localparam logic [1:0] SEL_PIN_FIRST = 2'h1;
  localparam logic [1:0] SEL_PIN_SECOND = 2'h2;
  localparam logic [1:0] SEL_PIN_THIRTEENTH = 2'h3;
  // Writable bits per register; reserved bits read as zero.
  localparam logic [7:0] MEM_MASK = 8'h6F;
  localparam logic [7:0] IO_MASK = 8'h6F;
  localparam logic [7:0] PERIPH_MASK = 8'hFF;
endpackage : brc_pkg

// >>> core/brc_regs.sv
// Control register bank of the memory, I/O and peripheral step-down rails.
// Assumes a synchronous register strobe port and a power sequencer that
// pulses seq_apply when it moves rails to their target states.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Bits 6:5 pick the pin that selects first or second target voltage.
// - Select code 00 means sequencer control; 01, 10, 11 pick pins 1, 2, 13.
// - Bits 2:1 pick the pin whose edges switch the rail on or off.
// - Memory bit 3 is the sequencer target, applied only as default supply.
// - I/O and peripheral bit 3 is the sequencer target for the enable bit.
// - Peripheral bit 7 is the sequencer target for the rail switch.
module brc_regs
  import brc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [2:0] gpio_in,
  input wire logic seq_apply,
  input wire logic mem_default_supply,
  output logic mem_rail_on,
  output logic io_rail_on,
  output logic periph_rail_on,
  output logic periph_switch_closed,
  output logic mem_volt_second,
  output logic io_volt_second,
  output logic periph_volt_second
);
  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [7:0] ctrl_q [3];
  logic [7:0] ctrl_d [3];
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [2:0] vsel_q;
  logic [2:0] vsel_d;
  logic [2:0] on_rise;
  logic [2:0] on_fall;
  logic [2:0] v_rise;
  logic [2:0] v_fall;
  localparam logic [7:0] ADDRS [3] = '{MEM_CTRL_ADDR, IO_CTRL_ADDR, PERIPH_CTRL_ADDR};
  localparam logic [7:0] MASKS [3] = '{MEM_MASK, IO_MASK, PERIPH_MASK};

  // ****************************************************************
  // Per-rail pin trackers
  // ****************************************************************
  for (genvar i = 0; i < 3; i++) begin : g_rail
    brc_pin_track u_on (
      .clk(clk),
      .rst(rst),
      .sel(ctrl_q[i][ON_SEL_HI:ON_SEL_LO]),
      .pins(gpio_in),
      .rise(on_rise[i]),
      .fall(on_fall[i])
    );
    brc_pin_track u_volt (
      .clk(clk),
      .rst(rst),
      .sel(ctrl_q[i][VOLT_SEL_HI:VOLT_SEL_LO]),
      .pins(gpio_in),
      .rise(v_rise[i]),
      .fall(v_fall[i])
    );
  end

  // Next register values: software write first, then sequencer, then pin edges.
  // Hardware actions win over a same-cycle write so no pin event is lost.
  always_comb begin
    rdata_d = 8'h00;
    for (int i = 0; i < 3; i++) begin
      ctrl_d[i] = ctrl_q[i];
      vsel_d[i] = vsel_q[i];
      if (reg_wr && reg_addr == ADDRS[i]) begin
        ctrl_d[i] = reg_wdata & MASKS[i];
      end
      if (seq_apply && ctrl_q[i][ON_SEL_HI:ON_SEL_LO] == SEL_SEQ) begin
        if (i != 0 || mem_default_supply) begin
          ctrl_d[i][RAIL_ON_BIT] = ctrl_q[i][SEQ_TARGET_BIT];
        end
      end
      if (on_rise[i]) begin
        ctrl_d[i][RAIL_ON_BIT] = 1'b1;
      end
      if (on_fall[i]) begin
        ctrl_d[i][RAIL_ON_BIT] = 1'b0;
      end
      if (v_rise[i]) begin
        vsel_d[i] = 1'b0;
      end
      if (v_fall[i]) begin
        vsel_d[i] = 1'b1;
      end
      if (reg_rd && reg_addr == ADDRS[i]) begin
        rdata_d = ctrl_q[i];
      end
    end
    if (seq_apply) begin
      ctrl_d[2][SWITCH_BIT] = ctrl_q[2][SWITCH_TARGET_BIT];
    end
  end

  // Register all state.
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 3; i++) begin
        ctrl_q[i] <= CTRL_RESET;
      end
      vsel_q <= 3'h0;
      rdata_q <= 8'h00;
    end else begin
      for (int i = 0; i < 3; i++) begin
        ctrl_q[i] <= ctrl_d[i];
      end
      vsel_q <= vsel_d;
      rdata_q <= rdata_d;
    end
  end

  // ****************************************************************
  // Outputs, all straight from flip-flops
  // ****************************************************************
  assign reg_rdata = rdata_q;
  assign mem_rail_on = ctrl_q[0][RAIL_ON_BIT];
  assign io_rail_on = ctrl_q[1][RAIL_ON_BIT];
  assign periph_rail_on = ctrl_q[2][RAIL_ON_BIT];
  assign periph_switch_closed = ctrl_q[2][SWITCH_BIT];
  assign mem_volt_second = vsel_q[0];
  assign io_volt_second = vsel_q[1];
  assign periph_volt_second = vsel_q[2];

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Every check runs on the one clock and stays quiet while reset is held.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // A sequencer step on the I/O rail while no pin owns its enable.
  sequence s_io_seq;
    seq_apply && ctrl_q[1][ON_SEL_HI:ON_SEL_LO] == SEL_SEQ && !on_rise[1] && !on_fall[1];
  endsequence
  AST_IO_SEQ: assert property (s_io_seq |=> io_rail_on == $past(ctrl_q[1][SEQ_TARGET_BIT]))
    else $error("io rail did not take sequencer target");

  // The same step on the peripheral rail.
  sequence s_periph_seq;
    seq_apply && ctrl_q[2][ON_SEL_HI:ON_SEL_LO] == SEL_SEQ && !on_rise[2] && !on_fall[2];
  endsequence
  property p_periph_seq;
    s_periph_seq |=> periph_rail_on == $past(ctrl_q[2][SEQ_TARGET_BIT]);
  endproperty
  AST_PERIPH_SEQ: assert property (p_periph_seq)
    else $error("peripheral rail did not take sequencer target");

  // The memory rail takes its target only when it is a default supply.
  sequence s_mem_seq;
    seq_apply && ctrl_q[0][ON_SEL_HI:ON_SEL_LO] == SEL_SEQ && !on_rise[0] && !on_fall[0];
  endsequence
  property p_mem_seq;
    s_mem_seq ##0 mem_default_supply |=> mem_rail_on == $past(ctrl_q[0][SEQ_TARGET_BIT]);
  endproperty
  AST_MEM_SEQ: assert property (p_mem_seq)
    else $error("memory rail did not take sequencer target");
  property p_mem_nodef;
    seq_apply && !mem_default_supply && !on_rise[0] && !on_fall[0]
      && !(reg_wr && reg_addr == MEM_CTRL_ADDR) |=> $stable(mem_rail_on);
  endproperty
  AST_MEM_NODEF: assert property (p_mem_nodef)
    else $error("memory rail changed without default supply");

  // The switch follows its target on every step and otherwise moves only on a peripheral register write.
  property p_sw_seq;
    seq_apply |=> periph_switch_closed == $past(ctrl_q[2][SWITCH_TARGET_BIT]);
  endproperty
  AST_SW_SEQ: assert property (p_sw_seq)
    else $error("switch did not follow its target");
  property p_sw_hold;
    !seq_apply && !(reg_wr && reg_addr == PERIPH_CTRL_ADDR) |=> $stable(periph_switch_closed);
  endproperty
  AST_SW_HOLD: assert property (p_sw_hold)
    else $error("switch moved without a step or a write");

  // Pin edges drive the enable bits.
  AST_ON_RISE: assert property (on_rise[1] |=> io_rail_on)
    else $error("pin rise did not enable rail");
  AST_ON_RISE_MEM: assert property (on_rise[0] |=> mem_rail_on)
    else $error("pin rise did not enable memory rail");
  AST_ON_FALL: assert property (on_fall[2] |=> !periph_rail_on)
    else $error("pin fall did not disable rail");

  // Pin edges drive the voltage choice; code zero blocks enable edges and leaves the voltage choice alone.
  AST_V_FALL: assert property (v_fall[0] |=> mem_volt_second)
    else $error("voltage did not move to second target");
  AST_V_RISE: assert property (v_rise[1] |=> !io_volt_second)
    else $error("voltage did not move to first target");
  property p_sel_zero;
    ctrl_q[0][ON_SEL_HI:ON_SEL_LO] == SEL_SEQ |-> !on_rise[0] && !on_fall[0];
  endproperty
  AST_SEL_ZERO: assert property (p_sel_zero)
    else $error("sequencer-owned rail saw a pin edge");
  property p_volt_hold;
    ctrl_q[1][VOLT_SEL_HI:VOLT_SEL_LO] == SEL_SEQ |=> $stable(io_volt_second);
  endproperty
  AST_VOLT_HOLD: assert property (p_volt_hold)
    else $error("voltage choice moved under sequencer control");

  // Software side: masked writes land, reserved bits stay clear, reads return the register.
  property p_mem_wr;
    reg_wr && reg_addr == MEM_CTRL_ADDR && !seq_apply && !on_rise[0] && !on_fall[0] |=>
      ctrl_q[0] == ($past(reg_wdata) & MEM_MASK);
  endproperty
  AST_WR_LAND: assert property (p_mem_wr)
    else $error("memory write did not land");
  property p_io_reserved;
    reg_wr && reg_addr == IO_CTRL_ADDR ##1 !seq_apply |-> (ctrl_q[1] & ~IO_MASK) == 8'h00;
  endproperty
  AST_RESERVED: assert property (p_io_reserved)
    else $error("reserved bits stored");
  property p_read;
    reg_rd && reg_addr == PERIPH_CTRL_ADDR |=> reg_rdata == $past(ctrl_q[2]);
  endproperty
  AST_READ: assert property (p_read)
    else $error("read data wrong");
endmodule : brc_regs
`default_nettype wire

// >>> test/brc_tb.sv
// Self-checking bench for the step-down rail control register bank.
// Assumes brc_regs and brc_pkg; the bench drives every port itself.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import brc_pkg::*;
  logic clk, rst, reg_wr, reg_rd, seq_apply, mem_default_supply;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [2:0] gpio_in;
  logic mem_rail_on, io_rail_on, periph_rail_on, periph_switch_closed;
  logic mem_volt_second, io_volt_second, periph_volt_second;
  logic [7:0] outs;
  int bad_count, n_checks;
  // Rows of address and expected read back after writing all ones; two are unmapped.
  logic [7:0] row_a [5] = '{MEM_CTRL_ADDR, IO_CTRL_ADDR, PERIPH_CTRL_ADDR, 8'h26, 8'h22};
  logic [7:0] row_e [5] = '{8'h6F, 8'h6F, 8'hFF, 8'h00, 8'h00};
  // All control outputs packed so one compare covers them.
  assign outs = {1'b0, mem_rail_on, io_rail_on, periph_rail_on, periph_switch_closed,
                 mem_volt_second, io_volt_second, periph_volt_second};
  brc_regs i_brc_regs (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gpio_in(gpio_in),
    .seq_apply(seq_apply), .mem_default_supply(mem_default_supply),
    .mem_rail_on(mem_rail_on), .io_rail_on(io_rail_on), .periph_rail_on(periph_rail_on),
    .periph_switch_closed(periph_switch_closed), .mem_volt_second(mem_volt_second),
    .io_volt_second(io_volt_second), .periph_volt_second(periph_volt_second));
  // 200 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  // Read data are only valid in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask : rd
  task automatic pin(input logic [2:0] v);
    @(posedge clk);
    gpio_in <= v;
    cyc(2);
  endtask : pin
  task automatic seq();
    @(posedge clk);
    seq_apply <= 1'b1;
    @(posedge clk);
    seq_apply <= 1'b0;
    cyc(1);
  endtask : seq
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  // Cuts a hang short and reports it as a mismatch.
  initial begin
    #100000;
    bad_count++;
    close_out();
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, seq_apply, mem_default_supply} = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    gpio_in = 3'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    cyc(1);
    chk(outs, 8'h00);
    for (int i = 0; i < 3; i++) rd(row_a[i], CTRL_RESET);
    // Writes with an idle cycle between strobes, then read back with reserved bits cleared.
    for (int i = 0; i < 5; i++) wr(row_a[i], 8'hFF);
    for (int i = 0; i < 5; i++) rd(row_a[i], row_e[i]);
    chk(outs, 8'h78);
    for (int i = 0; i < 3; i++) wr(row_a[i], 8'h00);
    chk(outs, 8'h00);
    // Each pin code drives enable and voltage choice of the I/O rail.
    for (int k = 1; k < 4; k++) begin
      wr(IO_CTRL_ADDR, 8'((k << 5) | (k << 1)));
      cyc(1);
      pin(3'h7 ^ 3'(1 << (k - 1)));
      chk(outs, (k == 1) ? 8'h00 : 8'h02);
      pin(3'(1 << (k - 1)));
      chk(outs, 8'h20);
      pin(3'h0);
      chk(outs, 8'h02);
    end
    wr(IO_CTRL_ADDR, 8'h00);
    // The sequencer applies targets; memory only as a default supply.
    wr(PERIPH_CTRL_ADDR, 8'h88);
    wr(MEM_CTRL_ADDR, 8'h08);
    seq();
    chk(outs, 8'h1A);
    mem_default_supply <= 1'b1;
    seq();
    chk(outs, 8'h5A);
    rd(PERIPH_CTRL_ADDR, 8'h99);
    cyc(1);
    chk(reg_rdata, 8'h00);
    // Memory and peripheral rails follow their own pins for enable and voltage.
    wr(MEM_CTRL_ADDR, 8'h22);
    wr(PERIPH_CTRL_ADDR, 8'h44);
    chk(outs, 8'h02);
    cyc(1);
    pin(3'h3);
    chk(outs, 8'h52);
    pin(3'h0);
    chk(outs, 8'h07);
    // The I/O rail takes a sequencer target of one.
    wr(IO_CTRL_ADDR, 8'h08);
    seq();
    chk(outs, 8'h27);
    // A pin edge wins over a write to the same bit in the same cycle.
    wr(IO_CTRL_ADDR, 8'h02);
    cyc(1);
    @(posedge clk);
    gpio_in <= 3'h1;
    reg_addr <= IO_CTRL_ADDR;
    reg_wdata <= 8'h02;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
    chk(outs, 8'h63);
    pin(3'h0);
    chk(outs, 8'h07);
    // Reset in mid-run returns every register and output to zero.
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    cyc(1);
    chk(outs, 8'h00);
    for (int i = 0; i < 3; i++) rd(row_a[i], CTRL_RESET);
    close_out();
  end
endmodule : testbench
`default_nettype wire
